// ---- core/mhs_top.sv ----
// Modem handshake and status block of a serial controller.
// Assumes host strobes and modem inputs synchronous to core_clk.
//
// Notes on behaviour
// R1: Status bit 4 is inverted clear-to-send.
// R2: Bit 0 flags clear-to-send change since read.
// R3: Clear-to-send never gates the transmitter.
// R4: Status bit 7 is inverted carrier detect.
// R5: Bit 3 flags carrier detect change.
// R6: Carrier detect never gates the receiver.
// R7: Status bit 5 is inverted data-set-ready.
// R8: Bit 1 flags data-set-ready change.
// R9: Interrupt on clear-to-send or carrier change.
// R10: Interrupt on data-set-ready change.
// R11: Terminal-ready pin low when control bit set.
// R12: Master reset forces terminal-ready high.
// R13: Loopback holds terminal-ready high.
// R14: Driver disable low throughout host reads.
// R15: Eight-line bus, driven only during reads.
// R16: Reading modem status clears change flags.
`timescale 1ns/1ps
module mhs_top
    import mhs_pkg::*;
#(
    parameter int DATA_W = MHS_DATA_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic master_reset_in,
    // Host bus
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic sel_status,
    input wire logic sel_control,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n,
    output logic bus_driver_disable,
    // Configuration
    input wire logic loopback_en,
    input wire logic modem_irq_en,
    // Modem pins
    input wire logic cts_n,
    input wire logic dcd_n,
    input wire logic dsr_n,
    output logic dtr_n,
    // Status towards other blocks
    output logic modem_irq,
    output logic [DATA_W-1:0] modem_status
);

    // ------------------------------------------------------------
    // Change detection
    // ------------------------------------------------------------
    logic rst_all_n;
    logic rd_status;
    logic rd_status_q;
    logic rd_end;
    logic cts_lvl_q;
    logic dcd_lvl_q;
    logic dsr_lvl_q;
    logic cts_change_flag;
    logic carrier_change_flag;
    logic dsr_change_flag;

    assign rst_all_n = reset_n & ~master_reset_in;
    assign rd_status = host_rd & sel_status;
    // Flags clear as the status read ends so the read sees them.
    assign rd_end = rd_status_q & ~rd_status; // R16

    // Status pins feed only status and interrupt logic.
    mhs_edge_flag u_cts (
        .core_clk(core_clk),
        .reset_n(rst_all_n),
        .pin_n(cts_n),
        .clear(rd_end),
        .level_q(cts_lvl_q),
        .flag_q(cts_change_flag)
    ); // R2 R3
    mhs_edge_flag u_dcd (
        .core_clk(core_clk),
        .reset_n(rst_all_n),
        .pin_n(dcd_n),
        .clear(rd_end),
        .level_q(dcd_lvl_q),
        .flag_q(carrier_change_flag)
    ); // R5 R6
    mhs_edge_flag u_dsr (
        .core_clk(core_clk),
        .reset_n(rst_all_n),
        .pin_n(dsr_n),
        .clear(rd_end),
        .level_q(dsr_lvl_q),
        .flag_q(dsr_change_flag)
    ); // R8

    // ------------------------------------------------------------
    // Status image and control
    // ------------------------------------------------------------
    logic [DATA_W-1:0] status_img;
    logic [DATA_W-1:0] mcr_d;
    logic [DATA_W-1:0] mcr_q;
    logic [DATA_W-1:0] status_q;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;
    logic irq_d;
    logic irq_q;
    logic dtr_d;
    logic dtr_q;
    logic rd_q_d;

    always_comb begin
        status_img = '0;
        status_img[MHS_MSR_CTS] = ~cts_lvl_q; // R1
        status_img[MHS_MSR_DCD] = ~dcd_lvl_q; // R4
        status_img[MHS_MSR_DSR] = ~dsr_lvl_q; // R7
        status_img[MHS_MSR_CTS_CHG] = cts_change_flag; // R2
        status_img[MHS_MSR_DCD_CHG] = carrier_change_flag; // R5
        status_img[MHS_MSR_DSR_CHG] = dsr_change_flag; // R8
    end

    always_comb begin
        mcr_d = mcr_q;
        if (host_wr && sel_control) begin
            mcr_d = data_in;
        end
        // R11 R13
        dtr_d = loopback_en ? 1'b1 : ~mcr_q[MHS_MCR_DTR];
        // Interrupt held while any change flag stands and enabled.
        irq_d = modem_irq_en & (cts_change_flag | carrier_change_flag | dsr_change_flag); // R9 R10
        rdata_d = rdata_q;
        if (host_rd) begin
            rdata_d = sel_status ? status_img : (sel_control ? mcr_q : '0);
        end
        rd_q_d = rd_status;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_all_n) begin
            mcr_q <= MHS_MCR_RESET;
            status_q <= MHS_MSR_RESET;
            rdata_q <= '0;
            irq_q <= 1'b0;
            dtr_q <= 1'b1; // R12
            rd_status_q <= 1'b0;
        end else begin
            mcr_q <= mcr_d;
            status_q <= status_img;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            dtr_q <= dtr_d;
            rd_status_q <= rd_q_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign data_out = host_rd ? rdata_d : rdata_q;
    assign data_oe_n = ~host_rd; // R15
    assign bus_driver_disable = ~host_rd; // R14
    assign dtr_n = dtr_q;
    assign modem_irq = irq_q;
    assign modem_status = status_q;

endmodule

// ---- core/mhs_pkg.sv ----
// Package for the modem handshake and status block.
// Assumes a single core clock; holds field positions and reset values.
package mhs_pkg;

    // ------------------------------------------------------------
    // Modem status image bit positions
    // ------------------------------------------------------------
    localparam int MHS_MSR_CTS_CHG = 0;
    localparam int MHS_MSR_DSR_CHG = 1;
    localparam int MHS_MSR_DCD_CHG = 3;
    localparam int MHS_MSR_CTS = 4;
    localparam int MHS_MSR_DSR = 5;
    localparam int MHS_MSR_DCD = 7;

    // ------------------------------------------------------------
    // Modem control bit positions and reset values
    // ------------------------------------------------------------
    localparam int MHS_MCR_DTR = 0;
    localparam logic [7:0] MHS_MCR_RESET = 8'h00;
    localparam logic [7:0] MHS_MSR_RESET = 8'h00;
    localparam logic [2:0] MHS_PINS_RESET = 3'h7;
    localparam int MHS_DATA_W = 8;

endpackage

// ---- core/mhs_edge_flag.sv ----
// Change-detect flag for one active-low modem status input.
// Assumes the input is already synchronous to core_clk.
`timescale 1ns/1ps
module mhs_edge_flag
    import mhs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Status input and clear
    input wire logic pin_n,
    input wire logic clear,
    // Results
    output logic level_q,
    output logic flag_q
);

    logic level_d;
    logic flag_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        level_d = pin_n;
        // A change arriving in the clearing cycle is kept.
        if (pin_n != level_q) begin
            flag_d = 1'b1;
        end else if (clear) begin
            flag_d = 1'b0;
        end else begin
            flag_d = flag_q;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            level_q <= 1'b1;
            flag_q <= 1'b0;
        end else begin
            level_q <= level_d;
            flag_q <= flag_d;
        end
    end

endmodule

// ---- verification/mhs_chk.sv ----
// Assertions on the ports of mhs_top.
// Assumes one clock; bound by name.
`timescale 1ns/1ps
module mhs_chk (
    // Inputs
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic master_reset_in,
    input wire logic host_rd,
    input wire logic loopback_en,
    input wire logic modem_irq_en,
    input wire logic cts_n,
    input wire logic dcd_n,
    // Outputs
    input wire logic data_oe_n,
    input wire logic bus_driver_disable,
    input wire logic dtr_n,
    input wire logic modem_irq,
    input wire logic [7:0] modem_status
);
    logic [2:0] run_q;
    always_ff @(posedge core_clk) run_q <= {run_q[1:0], reset_n & ~master_reset_in};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n || master_reset_in);
    a_read_disable: assert property (bus_driver_disable == !host_rd) else $error("driver disable");
    a_read_oe: assert property (data_oe_n == !host_rd) else $error("oe");
    a_cts_level: assert property (run_q[1:0] == 2'h3 |-> modem_status[4] == !$past(cts_n, 2))
        else $error("cts level");
    a_dcd_level: assert property (run_q[1:0] == 2'h3 |-> modem_status[7] == !$past(dcd_n, 2))
        else $error("dcd level");
    a_cts_flag: assert property (run_q == 3'h7 && $past(cts_n, 2) != $past(cts_n, 3) |-> modem_status[0])
        else $error("cts flag");
    a_irq_level: assert property (run_q[0] |-> modem_irq == ($past(modem_irq_en) && |(modem_status & 8'h0B)))
        else $error("irq");
    a_loop_dtr: assert property (loopback_en [*3] |-> dtr_n) else $error("loop dtr");
    a_reset_dtr: assert property (disable iff (1'b0) !reset_n || master_reset_in |=> dtr_n && !modem_irq)
        else $error("reset dtr");
endmodule
bind mhs_top mhs_chk i_mhs_chk (.*);

// ---- verification/mhs_modem.sv ----
// Modem model driving the status lines.
// Assumes the bench asks for levels.
`timescale 1ns/1ps
module mhs_modem (
    // Request
    input wire logic core_clk,
    input wire logic [2:0] want,
    // Lines
    output logic cts_n,
    output logic dsr_n,
    output logic dcd_n
);
    always_ff @(posedge core_clk) {dcd_n, dsr_n, cts_n} <= want;
endmodule

// ---- verification/mhs_top_test.sv ----
// Testbench for mhs_top with a modem model.
// Assumes mhs_chk is bound beside it.
`timescale 1ns/1ps
module mhs_top_test;
    logic core_clk = 0, reset_n = 0, master_reset_in = 0, host_rd = 0, host_wr = 0;
    logic sel_status = 0, sel_control = 0, loopback_en = 0, modem_irq_en = 0;
    logic [7:0] data_in = 8'h00, data_out, modem_status, v, e, m = 8'h00;
    logic [2:0] want = 3'h7, old = 3'h7;
    logic cts_n, dcd_n, dsr_n, dtr_n, data_oe_n, bus_driver_disable, modem_irq;
    int failures = 0, checks = 0;
    mhs_top i_mhs_top (.*);
    mhs_modem i_mhs_modem (.*);
    initial forever #4 core_clk = ~core_clk;
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        checks++;
        if (g !== x) begin
            failures++;
            $display("MISMATCH t=%0t %h %h", $time, g, x);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    function automatic logic [7:0] img(input logic [2:0] p, input logic [2:0] o);
        return {~p[2], 1'b0, ~p[1], ~p[0], p[2] ^ o[2], 1'b0, p[1] ^ o[1], p[0] ^ o[0]};
    endfunction
    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        v = 8'($urandom(44));
        tick(12);
        reset_n <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            want <= i < 2 ? 3'h0 : 3'($urandom);
            modem_irq_en <= i[0];
            tick(6);
            // Outputs are looked at half a cycle after the edge that launches them.
            @(negedge core_clk);
            e = img(want, old);
            chk({7'h00, modem_irq}, {7'h00, modem_irq_en & |(e & 8'h0B)});
            chk(modem_status, e);
            @(posedge core_clk);
            host_rd <= 1'b1;
            sel_status <= 1'b1;
            @(negedge core_clk);
            chk(data_out, e);
            chk({6'h00, data_oe_n, bus_driver_disable}, 8'h00);
            @(posedge core_clk);
            host_rd <= 1'b0;
            sel_status <= 1'b0;
            old = want;
            tick(4);
            @(negedge core_clk);
            chk(modem_status, img(want, want));
            @(posedge core_clk);
        end
        $display("status test done");
        for (int i = 0; i < 16; i++) begin
            v = 8'($urandom);
            loopback_en <= v[1];
            host_wr <= 1'b1;
            sel_control <= v[2];
            data_in <= v;
            @(posedge core_clk);
            host_wr <= 1'b0;
            if (v[2])
                m = v;
            tick(2);
            host_rd <= 1'b1;
            @(negedge core_clk);
            chk({7'h00, dtr_n}, {7'h00, ~(m[0] & ~v[1])});
            chk(data_out, v[2] ? m : 8'h00);
            @(posedge core_clk);
            host_rd <= 1'b0;
        end
        $display("dtr test done");
        // Terminal ready is driven active first so that master reset has something to undo.
        loopback_en <= 1'b0;
        host_wr <= 1'b1;
        sel_control <= 1'b1;
        data_in <= 8'h01;
        @(posedge core_clk);
        host_wr <= 1'b0;
        tick(2);
        @(negedge core_clk);
        chk({7'h00, dtr_n}, 8'h00);
        @(posedge core_clk);
        master_reset_in <= 1'b1;
        @(posedge core_clk);
        master_reset_in <= 1'b0;
        @(negedge core_clk);
        chk({7'h00, dtr_n}, 8'h01);
        tick(4);
        @(negedge core_clk);
        chk({7'h00, dtr_n}, 8'h01);
        $display("reset test done");
        finish_test();
    end
endmodule
